// ---- oad_decode.sv ----
/*
  Operand addressing decode front end: byte-stream instruction decode,
  operand locator field, page registers, effective address and data
  layout helpers. Assumes one byte per cycle from fetch with a valid
  strobe, and a register file and memory outside.
*/
// Notes on behaviour
// - Longword uses even register then next
// - Byte data low eight bits, high kept
// - Bit 15 is MSB, bit 0 LSB
// - Memory bit ops pick bit of fetched operand
// - Words big-endian, high byte at even
// - Odd word address raises error, no write-back
// - Exception stack transfers always word sized
// - Stack pointer auto modes force word access
// - Auto step one for byte, two word
// - Stack pointer step always two
// - General format: locator, extension, opcode
// - Decimal and sync transfers carry zero prefix
// - Special format: opcode first, then locator
// - High nibble selects register addressing modes
// - Immediate and absolute locator byte codes
// - Size bit zero byte, one word
// - Register field maps to registers directly
// - Page register chosen by register number
// - Small mode ignores page registers except short base
// - PC-relative only for branches via opcode
// - Code page from vector in large mode
// - Large mode page byte tops address
// - Short absolute uses base high byte
`timescale 1ns/1ns
`default_nettype none
`include "oad_regs.svh"

module oad_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic special_start,
  input wire logic special_two_op,
  input wire logic special_has_ea,
  input wire logic prefix_expected,
  input wire logic branch_op,
  input wire logic [1:0] branch_disp_len,
  // Mode and page register loads
  input wire logic large_mode,
  input wire logic vector_load,
  input wire logic [7:0] vector_page,
  input wire logic page_load,
  input wire logic [2:0] page_sel,
  input wire logic [7:0] page_data,
  // Register and memory data
  input wire logic [15:0] reg_value,
  input wire logic exc_stack,
  input wire logic [15:0] mem_word,
  input wire logic [3:0] bit_number,
  input wire logic [15:0] pc_value,
  input wire logic [15:0] long_hi,
  input wire logic [15:0] long_lo,
  input wire logic [15:0] old_reg,
  input wire logic [7:0] byte_result,
  // Decoded results
  output oad_pkg::oad_operand_t operand,
  output oad_pkg::oad_access_t access,
  output logic [15:0] reg_update,
  output logic reg_write,
  output logic [15:0] branch_target,
  output logic bit_value,
  output logic [15:0] merged_reg,
  output logic [2:0] long_hi_reg,
  output logic [2:0] long_lo_reg,
  output logic long_reg_error,
  output logic [31:0] long_value,
  output logic [7:0] mem_byte_even,
  output logic [7:0] mem_byte_odd,
  output logic prefix_error,
  output oad_pkg::oad_pages_t pages
);
  import oad_pkg::*;

  typedef struct packed {
    oad_state_t st;
    oad_operand_t op;
    logic [1:0] ext_left;
    logic [1:0] ext_cnt;
    logic is_branch;
    logic [15:0] target;
    oad_pages_t pg;
    oad_access_t acc;
    logic [15:0] rupd;
    logic rwr;
    logic bitv;
    logic [15:0] merged;
    logic [2:0] lhi;
    logic [2:0] llo;
    logic lerr;
    logic [31:0] lval;
    logic [7:0] mev;
    logic [7:0] mod;
    logic perr;
  } oad_dec_state_t;

  oad_dec_state_t s_ff;
  oad_dec_state_t nxt_s;
  oad_access_t acc_c;
  logic [15:0] upd_c;
  logic wr_c;

  // Locator field to mode and extension length
  function automatic logic [5:0] locate(input logic [7:0] b);
    oad_mode_t m;
    logic [1:0] n;
    m = OAD_AM_NONE;
    n = 2'd0;
    unique case (b[7:4])
      `OAD_MODE_REG_DIRECT: m = OAD_AM_REG;
      `OAD_MODE_INDIRECT: m = OAD_AM_IND;
      `OAD_MODE_DISP8: begin m = OAD_AM_DISP8; n = 2'd1; end
      `OAD_MODE_DISP16: begin m = OAD_AM_DISP16; n = 2'd2; end
      `OAD_MODE_PREDEC: m = OAD_AM_PREDEC;
      `OAD_MODE_POSTINC: m = OAD_AM_POSTINC;
      default: begin
        if (b == `OAD_LOC_IMM8) begin m = OAD_AM_IMM8; n = 2'd1; end
        else if (b == `OAD_LOC_IMM16) begin m = OAD_AM_IMM16; n = 2'd2; end
        else if (b[7:4] == `OAD_ABS_HI8 && b[2:0] == `OAD_ABS_LOW) begin
          m = OAD_AM_ABS8; n = 2'd1;
        end else if (b[7:4] == `OAD_ABS_HI16 && b[2:0] == `OAD_ABS_LOW) begin
          m = OAD_AM_ABS16; n = 2'd2;
        end
      end
    endcase
    return {m, n};
  endfunction

  // Sign-extended branch displacement add, wraps in 16 bits
  function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [15:0] d,
                                          input logic two);
    return pc + (two ? d : {{8{d[7]}}, d[7:0]});
  endfunction

  oad_addr_gen u_addr (
    .opnd(s_ff.op),
    .reg_value(reg_value),
    .pages(s_ff.pg),
    .large_mode(large_mode),
    .exc_stack(exc_stack),
    .access(acc_c),
    .reg_update(upd_c),
    .reg_write(wr_c)
  );

  // Next state: sequencer, page loads and data layout
  always_comb begin
    logic [5:0] loc;
    loc = locate(byte_data);
    nxt_s = s_ff;
    nxt_s.op.valid = 1'b0;
    nxt_s.perr = 1'b0;
    if (byte_valid) begin
      unique case (s_ff.st)
        OAD_ST_FIRST: begin
          nxt_s.op.ext = 16'h0000;
          nxt_s.ext_cnt = 2'd0;
          nxt_s.op.prefixed = 1'b0;
          if (special_start) begin
            nxt_s.op.special = 1'b1;
            nxt_s.op.opcode = byte_data;
            nxt_s.is_branch = branch_op;
            if (branch_op) begin
              nxt_s.op.mode = OAD_AM_PCREL;
              nxt_s.ext_left = branch_disp_len;
              nxt_s.st = OAD_ST_EXT;
            end else if (special_two_op)
              nxt_s.st = OAD_ST_SPEC_OP2;
            else if (special_has_ea)
              nxt_s.st = OAD_ST_SPEC_EA;
            else
              nxt_s.op.valid = 1'b1;
          end else begin
            nxt_s.op.special = 1'b0;
            nxt_s.is_branch = 1'b0;
            nxt_s.op.mode = oad_mode_t'(loc[5:2]);
            nxt_s.op.word = byte_data[`OAD_SIZE_POS];
            nxt_s.op.reg_num = byte_data[2:0];
            nxt_s.ext_left = loc[1:0];
            nxt_s.st = (loc[1:0] != 2'd0) ? OAD_ST_EXT
                     : (prefix_expected ? OAD_ST_PREFIX : OAD_ST_OP);
          end
        end
        OAD_ST_EXT: begin
          nxt_s.op.ext = {s_ff.op.ext[7:0], byte_data};
          nxt_s.ext_cnt = s_ff.ext_cnt + 2'd1;
          nxt_s.ext_left = s_ff.ext_left - 2'd1;
          if (s_ff.ext_left == 2'd1) begin
            if (s_ff.op.special) begin
              nxt_s.st = OAD_ST_FIRST;
              nxt_s.op.valid = 1'b1;
              nxt_s.target = rel_add(pc_value, {s_ff.op.ext[7:0], byte_data},
                                     s_ff.ext_cnt == 2'd1);
            end else
              nxt_s.st = prefix_expected ? OAD_ST_PREFIX : OAD_ST_OP;
          end
        end
        OAD_ST_PREFIX: begin
          nxt_s.op.prefixed = 1'b1;
          nxt_s.perr = (byte_data != `OAD_PREFIX_BYTE);
          nxt_s.st = OAD_ST_OP;
        end
        OAD_ST_OP: begin
          nxt_s.op.opcode = byte_data;
          nxt_s.op.valid = 1'b1;
          nxt_s.st = OAD_ST_FIRST;
        end
        OAD_ST_SPEC_OP2: begin
          nxt_s.op.opcode = byte_data;
          if (special_has_ea)
            nxt_s.st = OAD_ST_SPEC_EA;
          else begin
            nxt_s.op.valid = 1'b1;
            nxt_s.st = OAD_ST_FIRST;
          end
        end
        OAD_ST_SPEC_EA: begin
          nxt_s.op.mode = oad_mode_t'(loc[5:2]);
          nxt_s.op.word = byte_data[`OAD_SIZE_POS];
          nxt_s.op.reg_num = byte_data[2:0];
          nxt_s.ext_left = loc[1:0];
          if (loc[1:0] != 2'd0)
            nxt_s.st = OAD_ST_EXT;
          else begin
            nxt_s.op.valid = 1'b1;
            nxt_s.st = OAD_ST_FIRST;
          end
        end
        default: nxt_s.st = OAD_ST_FIRST;
      endcase
    end
    // Registered address results of the decoded operand
    nxt_s.acc = acc_c;
    nxt_s.rupd = upd_c;
    nxt_s.rwr = wr_c && s_ff.op.valid;
    // Page register loads; code page from vector only in large mode
    if (vector_load && large_mode)
      nxt_s.pg.code_page = vector_page;
    if (page_load) begin
      unique case (page_sel)
        3'h0: nxt_s.pg.code_page = page_data;
        3'h1: nxt_s.pg.data_page = page_data;
        3'h2: nxt_s.pg.ext_page = page_data;
        3'h3: nxt_s.pg.stack_page = page_data;
        3'h4: nxt_s.pg.short_base = page_data;
        default: ;
      endcase
    end
    // Bit pick on fetched operand, bit 15 most significant
    nxt_s.bitv = s_ff.op.word ? mem_word[bit_number] : mem_word[bit_number[2:0]];
    // Byte merge keeps upper half
    nxt_s.merged = {old_reg[15:8], byte_result};
    // Longword register pairing
    nxt_s.lhi = {s_ff.op.reg_num[2:1], 1'b0};
    nxt_s.llo = {s_ff.op.reg_num[2:1], 1'b1};
    nxt_s.lerr = s_ff.op.reg_num[0];
    nxt_s.lval = {long_hi, long_lo};
    // Big-endian split of a word for memory
    nxt_s.mev = mem_word[15:8];
    nxt_s.mod = mem_word[7:0];
  end

  // State register; page registers reset to a fixed pattern for simulation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
      s_ff.pg <= {5{`OAD_PAGE_RESET}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flip-flops
  assign operand = s_ff.op;
  assign access = s_ff.acc;
  assign reg_update = s_ff.rupd;
  assign reg_write = s_ff.rwr;
  assign branch_target = s_ff.target;
  assign bit_value = s_ff.bitv;
  assign merged_reg = s_ff.merged;
  assign long_hi_reg = s_ff.lhi;
  assign long_lo_reg = s_ff.llo;
  assign long_reg_error = s_ff.lerr;
  assign long_value = s_ff.lval;
  assign mem_byte_even = s_ff.mev;
  assign mem_byte_odd = s_ff.mod;
  assign prefix_error = s_ff.perr;
  assign pages = s_ff.pg;

endmodule

`default_nettype wire

// ---- oad_regs.svh ----
/*
  Constants for the operand addressing decode block: field positions,
  mode codes, adjustments and reset values.
  Assumes inclusion by bare name from the package and modules.
*/
`ifndef OAD_REGS_SVH
`define OAD_REGS_SVH

`define OAD_MODE_REG_DIRECT 4'ha
`define OAD_MODE_PREDEC 4'hb
`define OAD_MODE_POSTINC 4'hc
`define OAD_MODE_INDIRECT 4'hd
`define OAD_MODE_DISP8 4'he
`define OAD_MODE_DISP16 4'hf
`define OAD_LOC_IMM8 8'h04
`define OAD_LOC_IMM16 8'h0c
`define OAD_ABS_HI8 4'h0
`define OAD_ABS_HI16 4'h1
`define OAD_ABS_LOW 3'h5
`define OAD_PREFIX_BYTE 8'h00
`define OAD_SIZE_POS 3
`define OAD_STACK_REG 3'h7
`define OAD_STEP_BYTE 16'h0001
`define OAD_STEP_WORD 16'h0002
`define OAD_PAGE_RESET 8'h00
`define OAD_TOP_BIT 4'hf

`endif

// ---- oad_pkg.sv ----
/*
  Types shared by the operand addressing decode block.
  Assumes the constants header sits beside it.
*/
`include "oad_regs.svh"

package oad_pkg;

  // Decoded addressing mode
  typedef enum logic [3:0] {
    OAD_AM_NONE = 4'h0,
    OAD_AM_REG = 4'h1,
    OAD_AM_IND = 4'h2,
    OAD_AM_DISP8 = 4'h3,
    OAD_AM_DISP16 = 4'h4,
    OAD_AM_PREDEC = 4'h5,
    OAD_AM_POSTINC = 4'h6,
    OAD_AM_IMM8 = 4'h7,
    OAD_AM_IMM16 = 4'h8,
    OAD_AM_ABS8 = 4'h9,
    OAD_AM_ABS16 = 4'ha,
    OAD_AM_PCREL = 4'hb
  } oad_mode_t;

  // Decode sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    OAD_ST_FIRST = 3'h0,
    OAD_ST_EXT = 3'h1,
    OAD_ST_PREFIX = 3'h3,
    OAD_ST_OP = 3'h2,
    OAD_ST_SPEC_OP2 = 3'h6,
    OAD_ST_SPEC_EA = 3'h7
  } oad_state_t;

  // Page registers
  typedef struct packed {
    logic [7:0] code_page;
    logic [7:0] data_page;
    logic [7:0] ext_page;
    logic [7:0] stack_page;
    logic [7:0] short_base;
  } oad_pages_t;

  // One memory access request
  typedef struct packed {
    logic valid;
    logic word;
    logic [23:0] addr;
    logic addr_error;
  } oad_access_t;

  // Decoded operand description
  typedef struct packed {
    logic valid;
    oad_mode_t mode;
    logic word;
    logic [2:0] reg_num;
    logic [15:0] ext;
    logic [7:0] opcode;
    logic prefixed;
    logic special;
  } oad_operand_t;

endpackage

// ---- oad_addr_gen.sv ----
/*
  Effective address former: page selection, displacement, auto steps,
  alignment check. Combinational; fed by the decode front end.
*/
`timescale 1ns/1ns
`default_nettype none
`include "oad_regs.svh"

module oad_addr_gen (
  // Decoded operand
  input wire oad_pkg::oad_operand_t opnd,
  input wire logic [15:0] reg_value,
  // Context
  input wire oad_pkg::oad_pages_t pages,
  input wire logic large_mode,
  input wire logic exc_stack,
  // Results
  output oad_pkg::oad_access_t access,
  output logic [15:0] reg_update,
  output logic reg_write
);
  import oad_pkg::*;

  // Page select by register number
  function automatic logic [7:0] page_of(input logic [2:0] rn, input oad_pages_t p);
    if (rn[2:1] == 2'b11)
      return p.stack_page;
    else if (rn[2])
      return p.ext_page;
    else
      return p.data_page;
  endfunction

  logic [15:0] step;
  logic [15:0] off;
  logic [7:0] page;
  logic stack_word;

  // Offset, step and size forcing
  always_comb begin
    stack_word = (opnd.reg_num == `OAD_STACK_REG) &&
      (opnd.mode == OAD_AM_PREDEC || opnd.mode == OAD_AM_POSTINC);
    step = (opnd.word || stack_word) ? `OAD_STEP_WORD : `OAD_STEP_BYTE;
    page = page_of(opnd.reg_num, pages);
    reg_write = 1'b0;
    reg_update = reg_value;
    off = reg_value;
    unique case (opnd.mode)
      OAD_AM_DISP8: off = reg_value + {{8{opnd.ext[7]}}, opnd.ext[7:0]};
      OAD_AM_DISP16: off = reg_value + opnd.ext;
      OAD_AM_PREDEC: begin
        off = reg_value - step;
        reg_update = off;
        reg_write = 1'b1;
      end
      OAD_AM_POSTINC: begin
        reg_update = reg_value + step;
        reg_write = 1'b1;
      end
      OAD_AM_ABS8: begin
        off = {pages.short_base, opnd.ext[7:0]};
        page = 8'h00;
      end
      OAD_AM_ABS16: begin
        off = opnd.ext;
        page = pages.data_page;
      end
      default: ;
    endcase
    access.valid = opnd.valid && (opnd.mode inside {OAD_AM_IND, OAD_AM_DISP8,
      OAD_AM_DISP16, OAD_AM_PREDEC, OAD_AM_POSTINC, OAD_AM_ABS8, OAD_AM_ABS16});
    access.word = opnd.word || stack_word || exc_stack;
    access.addr = {large_mode ? page : 8'h00, off};
    access.addr_error = access.valid && access.word && off[0];
    if (access.addr_error)
      reg_write = 1'b0;
  end

endmodule

`default_nettype wire

// ---- oad_decode_props.sv ----
/*
  Assertion checker for the operand addressing decoder ports.
  Assumes it is bound onto every oad_decode instance, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module oad_decode_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched inputs
  input wire logic exc_stack,
  input wire logic large_mode,
  input wire logic [15:0] reg_value,
  input wire logic [15:0] mem_word,
  input wire logic [3:0] bit_number,
  // Watched outputs
  input wire oad_pkg::oad_operand_t operand,
  input wire oad_pkg::oad_access_t access,
  input wire logic [15:0] reg_update,
  input wire logic reg_write,
  input wire logic bit_value,
  input wire logic [7:0] mem_byte_even,
  input wire logic long_reg_error
);
  import oad_pkg::*;
  logic [1:0] up_ff;
  // Data outputs are only meaningful three edges after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Auto-modify operand decoded, and the stack pointer case of it
  sequence auto_s;
    operand.valid && (operand.mode == OAD_AM_PREDEC || operand.mode == OAD_AM_POSTINC);
  endsequence
  sequence sp_auto_s;
    auto_s ##0 operand.reg_num == 3'h7;
  endsequence
  odd_word_a: assert property (access.valid && access.word && access.addr[0] |-> access.addr_error)
    else $error("odd word access not flagged");
  err_no_write_a: assert property (access.addr_error |-> !reg_write)
    else $error("write-back despite address error");
  sp_word_a: assert property (sp_auto_s ##1 access.valid |-> access.word)
    else $error("stack pointer access not word sized");
  sp_step_a: assert property (sp_auto_s ##1 reg_write |->
    16'(reg_update - $past(reg_value)) inside {16'h0002, 16'hfffe})
    else $error("stack pointer step not two");
  byte_step_a: assert property (auto_s ##0 !operand.word && operand.reg_num != 3'h7
    ##1 reg_write |-> 16'(reg_update - $past(reg_value)) inside {16'h0001, 16'hffff})
    else $error("byte auto step not one");
  exc_word_a: assert property (exc_stack && operand.valid ##1 access.valid |-> access.word)
    else $error("exception stack access not word sized");
  small_page_a: assert property (!large_mode && operand.valid ##1 access.valid
    |-> access.addr[23:16] == 8'h00)
    else $error("page byte used in small mode");
  byte_order_a: assert property (up_ff == 2'h3 |-> mem_byte_even == 8'($past(mem_word) >> 8))
    else $error("even address byte not high byte");
  bit_pick_a: assert property (up_ff == 2'h3 |-> bit_value == ($past(operand.word) ?
    1'($past(mem_word) >> $past(bit_number)) : 1'($past(mem_word) >> $past(bit_number[2:0]))))
    else $error("picked bit wrong");
  long_odd_a: assert property (up_ff == 2'h3 |-> long_reg_error == 1'($past(operand.reg_num)))
    else $error("odd longword register not flagged");
endmodule
bind oad_decode oad_decode_props props_i (.clk, .rst_b, .exc_stack, .large_mode, .reg_value,
  .mem_word, .bit_number, .operand, .access, .reg_update, .reg_write, .bit_value,
  .mem_byte_even, .long_reg_error);
`default_nettype wire

// ---- oad_reg_model.sv ----
/*
  General register file standing beside the decoder.
  Assumes the bench preloads a register before each instruction.
*/
`timescale 1ns/1ns
`default_nettype none
module oad_reg_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Decoder side
  input wire logic [2:0] reg_num,
  input wire logic reg_write,
  input wire logic [15:0] reg_update,
  // Bench preload
  input wire logic ld,
  input wire logic [2:0] ld_num,
  input wire logic [15:0] ld_val,
  output logic [15:0] reg_value
);
  logic [15:0] regs_ff [8];
  // Field value names the register of the same number
  assign reg_value = regs_ff[reg_num];
  // Preload wins over write-back, bench owns the value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regs_ff <= '{default: 16'h0000};
    end else if (ld) begin
      regs_ff[ld_num] <= ld_val;
    end else if (reg_write) begin
      regs_ff[reg_num] <= reg_update;
    end
  end
endmodule
`default_nettype wire

// ---- test_oad_decode.sv ----
/*
  Self-checking bench for the operand addressing decoder.
  Assumes the decoder, checker and register model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_oad_decode;
  import oad_pkg::*;
  logic clk, rst_b, byte_valid, special_start, special_two_op, special_has_ea;
  logic prefix_expected, branch_op, large_mode, vector_load, page_load, exc_stack;
  logic reg_write, bit_value, long_reg_error, prefix_error, ld, perr, sz, pe, ex, we;
  logic [1:0] branch_disp_len;
  logic [2:0] page_sel, long_hi_reg, long_lo_reg, ld_num, r3;
  logic [3:0] bit_number;
  logic [7:0] byte_data, vector_page, page_data, byte_result, mem_byte_even, mem_byte_odd;
  logic [7:0] eab, op;
  logic [15:0] reg_value, mem_word, pc_value, long_hi, long_lo, old_reg, reg_update;
  logic [15:0] branch_target, merged_reg, ld_val, v, st;
  logic [23:0] a;
  logic [31:0] long_value, t, x;
  logic [31:0] seed = 32'h17; // Xorshift state, starts at 23
  oad_operand_t operand;
  oad_access_t access;
  oad_pages_t pages, pg;
  int fail_count, checks, cyc, i;
  oad_mode_t em[10] = '{OAD_AM_REG, OAD_AM_IND, OAD_AM_DISP8, OAD_AM_DISP16, OAD_AM_PREDEC,
    OAD_AM_POSTINC, OAD_AM_ABS8, OAD_AM_ABS16, OAD_AM_IMM8, OAD_AM_IMM16};
  logic [3:0] nib[6] = '{4'ha, 4'hd, 4'he, 4'hf, 4'hb, 4'hc};
  int nx[10] = '{0, 0, 1, 2, 0, 0, 1, 2, 1, 2};

  oad_decode dut (.*);
  oad_reg_model regs (.clk, .rst_b, .reg_num(operand.reg_num), .reg_write, .reg_update, .ld,
    .ld_num, .ld_val, .reg_value);

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far above the roughly 1300 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (prefix_error === 1'b1) perr <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected effective address from mode, register, pages
  function automatic logic [23:0] ea(oad_mode_t m, logic [2:0] r, logic [15:0] b, st);
    logic [7:0] p;
    p = !large_mode ? 8'h00 : r < 4 ? pg.data_page : r < 6 ? pg.ext_page : pg.stack_page;
    case (m)
      OAD_AM_DISP8: ea = {p, 16'(b + {{8{x[7]}}, x[7:0]})};
      OAD_AM_DISP16: ea = {p, 16'(b + x[15:0])};
      OAD_AM_PREDEC: ea = {p, 16'(b - st)};
      OAD_AM_ABS8: ea = {8'h00, pg.short_base, x[7:0]};
      OAD_AM_ABS16: ea = {large_mode ? pg.data_page : 8'h00, x[15:0]};
      default: ea = {p, b};
    endcase
  endfunction

  task automatic chk(string w, logic [39:0] s, logic [39:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One instruction byte, taken at the following edge
  task automatic put(logic [7:0] b, logic s);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    special_start <= s;
    ld <= 1'b0;
  endtask
  task automatic done_wait();
    int n;
    @(posedge clk);
    byte_valid <= 1'b0;
    special_start <= 1'b0;
    n = 0;
    // Valid stands one cycle right after the last byte's edge
    #1;
    while (operand.valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", operand.valid, 1'b1);
  endtask
  task automatic set_pages(logic lm);
    t = rnd();
    large_mode <= lm;
    pg = {t, t[11:4]};
    for (int s = 0; s < 5; s++) begin
      @(posedge clk);
      page_load <= 1'b1;
      page_sel <= 3'(s);
      page_data <= pg[39-8*s -: 8];
    end
    @(posedge clk);
    page_load <= 1'b0;
    vector_load <= lm;
    vector_page <= t[19:12];
    if (lm) pg.code_page = t[19:12];
    @(posedge clk);
    vector_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("pages", pages, pg);
  endtask

  initial begin
    {byte_valid, special_start, special_two_op, special_has_ea, prefix_expected} = '0;
    {branch_op, large_mode, vector_load, page_load, exc_stack, ld, perr} = '0;
    {branch_disp_len, page_sel, bit_number, byte_data, vector_page, page_data} = '0;
    {byte_result, mem_word, pc_value, long_hi, long_lo, old_reg, ld_num, ld_val} = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset pages", pages, 40'h0);
    // Every locator code, random registers, sizes and values
    for (int k = 0; k < 200; k++) begin
      if (k % 100 == 0) set_pages(k >= 100);
      i = k % 10;
      t = rnd();
      x = rnd();
      r3 = (k % 3 == 0) ? 3'h7 : t[2:0];
      eab = i < 6 ? {nib[i], t[3], r3} : i < 8 ? {3'h0, i == 7, t[3], 3'h5} : i == 8 ? 8'h04 : 8'h0c;
      sz = eab[3];
      op = t[31:24];
      v = t[23:8];
      pe = (k % 5 == 1);
      ex = (i > 0 && i < 4 && k % 7 == 0);
      @(posedge clk);
      {ld, ld_num, ld_val, exc_stack, prefix_expected} <= {1'b1, r3, v, ex, pe};
      {mem_word, old_reg, bit_number, byte_result} <= {x, t[7:4], t[15:8]};
      {long_hi, long_lo} <= {v, x[31:16]};
      perr = 1'b0;
      put(eab, 1'b0);
      for (int n = nx[i]; n > 0; n--) put(x[8*n-1 -: 8], 1'b0);
      if (pe) put(8'h00, 1'b0);
      put(op, 1'b0);
      done_wait();
      chk("mode", operand.mode, em[i]);
      chk("opcode", operand.opcode, op);
      chk("prefixed", {operand.prefixed, perr}, {pe, 1'b0});
      if (i < 6) chk("reg", operand.reg_num, r3);
      if (i < 4 || i > 5) chk("word", operand.word, sz);
      if (nx[i] == 2) chk("ext", operand.ext, x[15:0]);
      we = sz | ex | (i > 3 && i < 6 && r3 == 3'h7);
      st = (sz || r3 == 3'h7) ? 16'h0002 : 16'h0001;
      a = ea(em[i], r3, v, st);
      @(posedge clk);
      #1;
      if (i > 0 && i < 8) chk("access", access, {1'b1, we, a, we & a[0]});
      if (i == 4 || i == 5) chk("write", reg_write, !(we & a[0]));
      if ((i == 4 || i == 5) && !(we & a[0]))
        chk("update", reg_update, i == 4 ? 16'(v - st) : 16'(v + st));
      chk("bytes", {mem_byte_even, mem_byte_odd}, x[31:16]);
      chk("bit", bit_value, sz ? x[16 + t[7:4]] : x[16 + t[6:4]]);
      chk("merge", merged_reg, {x[15:8], t[15:8]});
      chk("long", long_value, {v, x[31:16]});
      if (i < 6)
        chk("long reg", {long_hi_reg, long_lo_reg, long_reg_error},
            {r3[2:1], 1'b0, r3[2:1], 1'b1, r3[0]});
    end
    // Branches with one and two displacement bytes
    for (int k = 0; k < 10; k++) begin
      x = rnd();
      @(posedge clk);
      {branch_op, branch_disp_len, pc_value} <= {1'b1, k[0] ? 2'h2 : 2'h1, x[15:0]};
      put(x[7:0], 1'b1);
      if (k[0]) put(x[31:24], 1'b0);
      put(x[23:16], 1'b0);
      done_wait();
      v = k[0] ? x[31:16] : {{8{x[23]}}, x[23:16]};
      chk("branch", {operand.mode, operand.special}, {OAD_AM_PCREL, 1'b1});
      chk("target", branch_target, 16'(x[15:0] + v));
    end
    // Nonzero prefix byte, left to the end
    @(posedge clk);
    {branch_op, prefix_expected, exc_stack} <= 3'h2;
    perr = 1'b0;
    put(8'hd1, 1'b0);
    put(8'h5a, 1'b0);
    put(8'h11, 1'b0);
    done_wait();
    repeat (2) @(posedge clk);
    chk("prefix error", perr, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
